//--- hw/ssct_pkg.sv
// constants, types and register map for the subtract/sum/clz/trap unit
package ssct_pkg;

    localparam logic [7:0]  OFS_OPCODE     = 8'h00;
    localparam logic [7:0]  OFS_EXT        = 8'h04;
    localparam logic [7:0]  OFS_GO         = 8'h08;
    localparam logic [7:0]  OFS_EV_STATUS  = 8'h0C;
    localparam logic [7:0]  OFS_EV_CLEAR   = 8'h10;
    localparam logic [7:0]  OFS_EV_ENABLE  = 8'h14;
    localparam logic [7:0]  OFS_PC         = 8'h18;
    localparam logic [7:0]  OFS_SR         = 8'h1C;
    localparam logic [7:0]  OFS_REG_SEL    = 8'h20;
    localparam logic [7:0]  OFS_REG_DATA   = 8'h24;
    localparam logic [7:0]  OFS_STORE_ADDR = 8'h28;
    localparam logic [7:0]  OFS_STORE_DATA = 8'h2C;

    // status register layout
    localparam int SR_C       = 0;
    localparam int SR_Z       = 1;
    localparam int SR_N       = 2;
    localparam int SR_V       = 3;
    localparam int SR_M       = 4;
    localparam int SR_T       = 5;
    localparam int SR_L       = 6;
    localparam int SR_S       = 7;
    localparam int SR_ILC_LSB = 8;
    localparam int SR_FL_LSB  = 21;
    localparam int SR_FP_LSB  = 25;

    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam logic [31:0] SR_RESET = 32'h0000_0000;

    localparam int EV_RANGE = 0;
    localparam int EV_TRAP  = 1;
    localparam int EV_STORE = 2;
    localparam int EV_W     = 3;

    localparam logic [5:0] OPC_STACK_STORE = 6'h27;
    localparam logic [5:0] OPC_SUB         = 6'h12;
    localparam logic [5:0] OPC_SUB_BORROW  = 6'h10;
    localparam logic [5:0] OPC_SUB_TRAP    = 6'h13;
    localparam logic [5:0] OPC_SUM         = 6'h06;
    localparam logic [5:0] OPC_SUM_TRAP    = 6'h07;
    localparam logic [5:0] OPC_TRAP_HI     = 6'h3F;
    localparam logic [7:0] OPC_LZ_COUNT    = 8'h8E;

    localparam logic [23:0] TRAP_ENTRY_HI  = 24'hFFFFFF;
    localparam logic [3:0]  TRAP_FL_NEW    = 4'h6;
    localparam logic [4:0]  FL_ZERO_AS     = 5'h10;
    localparam logic [1:0]  TRAP_ILC       = 2'h1;
    localparam logic [5:0]  LZ_ALL_ZERO    = 6'h20;

    typedef struct packed {
        logic [15:0] op;
        logic [15:0] ext1;
        logic [15:0] ext2;
    } ssct_instr_type;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } ssct_wb_req_type;

endpackage : ssct_pkg

//--- hw/ssct_clz.sv
// leading zero counter for one 32-bit word
module ssct_clz (
    input  wire logic [31:0] val_i,
    output logic      [5:0]  count_o
);

    always_comb begin
        count_o = ssct_pkg::LZ_ALL_ZERO;
        for (int i = 0; i < 32; i++) begin
            if (val_i[i]) begin
                count_o = 6'(31 - i);
            end
        end
    end

endmodule : ssct_clz

//--- hw/ssct_exec.sv
// execution unit with wishbone register port and event interrupt
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
module ssct_exec #(
    parameter logic [31:0] RANGE_ERR_ENTRY = 32'hFFFF_FF00
) (
    input  wire logic        clk_sys_i,
    input  wire logic        arst_n_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    output logic             store_valid_o,
    output logic      [31:0] store_addr_o,
    output logic      [31:0] store_data_o
);

    ssct_pkg::ssct_wb_req_type   req;
    ssct_pkg::ssct_instr_type    instr_q;
    logic [31:0]                 pc_q;
    logic [31:0]                 sr_q;
    logic [31:0]                 gl_q [2:15];
    logic [31:0]                 lc_q [0:63];
    logic [4:0]                  reg_sel_q;
    logic [ssct_pkg::EV_W-1:0]   ev_status_q;
    logic [ssct_pkg::EV_W-1:0]   ev_enable_q;
    logic                        bus_rd;
    logic                        bus_wr;
    logic                        go;
    logic [31:0]                 next_rdata;

    // decoded fields and results
    logic        d_loc;
    logic        s_loc;
    logic [3:0]  rd_code;
    logic [3:0]  rs_code;
    logic [31:0] dst_val;
    logic [31:0] src_val;
    logic        src_is_sr;
    logic [31:0] dis;
    logic [31:0] kon;
    logic [5:0]  lz_count;
    logic [31:0] next_res;
    logic        next_wr;
    logic [31:0] next_pc;
    logic [31:0] next_sr;
    logic        next_range;
    logic        next_store;
    logic        next_trap;
    logic [31:0] trap_entry;
    logic [6:0]  fp;
    logic [4:0]  fl_eff;
    logic [31:0] ret_addr;
    logic [31:0] saved_sr;
    logic [31:0] trap_sr;

    assign req = '{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i};

    // answer one cycle after request; writes act on the edge that sees ack, read data is latched on the edge before
    assign bus_rd = req.cyc && req.stb && !req.we && !wb_ack_o;
    assign bus_wr = req.cyc && req.stb && req.we && wb_ack_o;
    assign go     = bus_wr && (req.adr == ssct_pkg::OFS_GO);

    assign fp     = sr_q[ssct_pkg::SR_FP_LSB +: 7];
    assign fl_eff = (sr_q[ssct_pkg::SR_FL_LSB +: 4] == 4'h0) ?
                    ssct_pkg::FL_ZERO_AS :
                    {1'b0, sr_q[ssct_pkg::SR_FL_LSB +: 4]};

    function automatic logic [5:0] loc_idx(input logic [3:0] code);
        loc_idx = fp[5:0] + {2'b00, code};
    endfunction : loc_idx

    function automatic logic [31:0] rd_reg(input logic       loc,
                                           input logic [3:0] code);
        if (loc) begin
            rd_reg = lc_q[loc_idx(code)];
        end else if (code == 4'h0) begin
            rd_reg = pc_q;
        end else if (code == 4'h1) begin
            rd_reg = sr_q;
        end else begin
            rd_reg = gl_q[code];
        end
    endfunction : rd_reg

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = sel[i] ? dat[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : merge

    // sign, short part and optional long part; short width set by wide_short
    function automatic logic [31:0] sext(input logic [15:0] e1,
                                         input logic [15:0] e2,
                                         input logic        wide_short);
        if (wide_short) begin
            sext = e1[15] ? {{2{e1[14]}}, e1[13:0], e2}
                          : {{18{e1[14]}}, e1[13:0]};
        end else begin
            sext = e1[15] ? {{4{e1[14]}}, e1[11:0], e2}
                          : {{20{e1[14]}}, e1[11:0]};
        end
    endfunction : sext

    function automatic logic cond_met(input logic [3:0]  code,
                                      input logic [31:0] sr);
        logic n;
        logic z;
        logic c;
        n = sr[ssct_pkg::SR_N];
        z = sr[ssct_pkg::SR_Z];
        c = sr[ssct_pkg::SR_C];
        case (code)
            4'h4: cond_met = n || z;
            4'h5: cond_met = !n && !z;
            4'h6: cond_met = n;
            4'h7: cond_met = !n;
            4'h8: cond_met = c || z;
            4'h9: cond_met = !c && !z;
            4'hA: cond_met = c;
            4'hB: cond_met = !c;
            4'hC: cond_met = z;
            4'hD: cond_met = !z;
            4'hE: cond_met = sr[ssct_pkg::SR_V];
            4'hF: cond_met = 1'b1;
            default: cond_met = 1'b0;
        endcase
    endfunction : cond_met

    ssct_clz ssct_clz_i (
        .val_i   (lc_q[loc_idx(instr_q.op[3:0])]),
        .count_o (lz_count)
    );

    assign d_loc     = instr_q.op[9];
    assign s_loc     = instr_q.op[8];
    assign rd_code   = instr_q.op[7:4];
    assign rs_code   = instr_q.op[3:0];
    assign dst_val   = rd_reg(d_loc, rd_code);
    assign src_is_sr = !s_loc && (rs_code == 4'h1);
    assign src_val   = rd_reg(s_loc, rs_code);
    assign dis       = sext(instr_q.ext1, instr_q.ext2, 1'b0);
    assign kon       = sext(instr_q.ext1, instr_q.ext2, 1'b1);

    assign trap_entry = {ssct_pkg::TRAP_ENTRY_HI, instr_q.op[7:2], 2'b00};
    assign ret_addr   = pc_q + 32'h0000_0002;
    always_comb begin
        saved_sr = sr_q;
        saved_sr[ssct_pkg::SR_ILC_LSB +: 2] = ssct_pkg::TRAP_ILC;
        trap_sr = sr_q;
        trap_sr[ssct_pkg::SR_S] = 1'b1;
        trap_sr[ssct_pkg::SR_FP_LSB +: 7] = fp + {2'b00, fl_eff};
        trap_sr[ssct_pkg::SR_FL_LSB +: 4] = ssct_pkg::TRAP_FL_NEW;
        trap_sr[ssct_pkg::SR_M] = 1'b0;
        trap_sr[ssct_pkg::SR_T] = 1'b0;
        trap_sr[ssct_pkg::SR_L] = 1'b1;
    end

    always_comb begin
        logic [32:0] wide;
        logic [31:0] sub_b;
        logic        cin;
        logic        v;
        logic [1:0]  len;
        wide       = '0;
        sub_b      = '0;
        cin        = 1'b0;
        v          = 1'b0;
        len        = instr_q.ext1[15] ? 2'd3 : 2'd2;
        next_res   = '0;
        next_wr    = 1'b0;
        next_sr    = sr_q;
        next_range = 1'b0;
        next_store = 1'b0;
        next_trap  = 1'b0;
        case (instr_q.op[15:10])
            ssct_pkg::OPC_SUB, ssct_pkg::OPC_SUB_BORROW,
            ssct_pkg::OPC_SUB_TRAP: begin
                len = 2'd1;
                // status source: carry is the whole subtrahend
                sub_b = src_is_sr ? {31'h0, sr_q[ssct_pkg::SR_C]}
                                  : src_val;
                cin = (instr_q.op[15:10] == ssct_pkg::OPC_SUB_BORROW) &&
                      !src_is_sr && sr_q[ssct_pkg::SR_C];
                wide = {1'b0, dst_val} - {1'b0, sub_b} - {32'h0, cin};
                v = (dst_val[31] != sub_b[31]) &&
                    (wide[31] != dst_val[31]);
                next_res = wide[31:0];
                next_wr  = 1'b1;
                next_sr[ssct_pkg::SR_Z] = (wide[31:0] == 32'h0);
                if (instr_q.op[15:10] == ssct_pkg::OPC_SUB_BORROW) begin
                    next_sr[ssct_pkg::SR_Z] = sr_q[ssct_pkg::SR_Z] &&
                                              (wide[31:0] == 32'h0);
                end
                next_sr[ssct_pkg::SR_N] = wide[31];
                next_sr[ssct_pkg::SR_V] = v;
                if (instr_q.op[15:10] == ssct_pkg::OPC_SUB_TRAP) begin
                    next_range = v;
                end else begin
                    next_sr[ssct_pkg::SR_C] = wide[32];
                end
            end
            ssct_pkg::OPC_SUM, ssct_pkg::OPC_SUM_TRAP: begin
                sub_b = src_is_sr ? {31'h0, sr_q[ssct_pkg::SR_C]}
                                  : src_val;
                wide = {1'b0, sub_b} + {1'b0, kon};
                v = (sub_b[31] == kon[31]) && (wide[31] != sub_b[31]);
                next_res = wide[31:0];
                next_wr  = 1'b1;
                next_sr[ssct_pkg::SR_Z] = (wide[31:0] == 32'h0);
                next_sr[ssct_pkg::SR_N] = wide[31];
                next_sr[ssct_pkg::SR_V] = v;
                if (instr_q.op[15:10] == ssct_pkg::OPC_SUM_TRAP) begin
                    next_range = v;
                end else begin
                    next_sr[ssct_pkg::SR_C] = wide[32];
                end
            end
            ssct_pkg::OPC_STACK_STORE: begin
                // address update happens even if the store faults
                next_res   = dst_val + dis;
                next_wr    = 1'b1;
                next_store = 1'b1;
            end
            ssct_pkg::OPC_TRAP_HI: begin
                len = 2'd1;
                next_trap = cond_met({instr_q.op[9:8], instr_q.op[1:0]},
                                     sr_q);
            end
            default: begin
                len = 2'd1;
                if (instr_q.op[15:8] == ssct_pkg::OPC_LZ_COUNT) begin
                    next_res = {26'h0, lz_count};
                    next_wr  = 1'b1;
                end
            end
        endcase
        next_pc = pc_q + {29'h0, len, 1'b0};
        if (next_range) begin
            next_pc = RANGE_ERR_ENTRY;
        end else if (next_wr && !d_loc && rd_code == 4'h0 &&
                     instr_q.op[15:8] != ssct_pkg::OPC_LZ_COUNT) begin
            next_pc = next_res;
        end
    end

    // architectural state: program counter, status, register banks
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pc_q <= ssct_pkg::PC_RESET;
            sr_q <= ssct_pkg::SR_RESET;
            for (int i = 2; i < 16; i++) begin
                gl_q[i] <= 32'h0000_0000;
            end
            for (int i = 0; i < 64; i++) begin
                lc_q[i] <= 32'h0000_0000;
            end
        end else if (go && next_trap) begin
            pc_q <= trap_entry;
            sr_q <= trap_sr;
            // both slots use the effective length so they stay adjacent
            lc_q[6'(fp + {2'b00, fl_eff})] <=
                {ret_addr[31:1], sr_q[ssct_pkg::SR_S]};
            lc_q[6'(fp + {2'b00, fl_eff} + 7'h01)] <= saved_sr;
        end else if (go) begin
            pc_q <= next_pc;
            sr_q <= next_sr;
            if (next_wr) begin
                if (instr_q.op[15:8] == ssct_pkg::OPC_LZ_COUNT) begin
                    lc_q[loc_idx(rd_code)] <= next_res;
                end else if (d_loc) begin
                    lc_q[loc_idx(rd_code)] <= next_res;
                end else if (rd_code > 4'h1) begin
                    gl_q[rd_code] <= next_res;
                end
            end
        end else if (bus_wr) begin
            if (req.adr == ssct_pkg::OFS_PC) begin
                pc_q <= merge(pc_q, req.dat, req.sel);
            end else if (req.adr == ssct_pkg::OFS_SR) begin
                sr_q <= merge(sr_q, req.dat, req.sel);
            end else if (req.adr == ssct_pkg::OFS_REG_DATA) begin
                if (reg_sel_q[4]) begin
                    lc_q[loc_idx(reg_sel_q[3:0])] <=
                        merge(lc_q[loc_idx(reg_sel_q[3:0])], req.dat, req.sel);
                end else if (reg_sel_q[3:0] == 4'h0) begin
                    pc_q <= merge(pc_q, req.dat, req.sel);
                end else if (reg_sel_q[3:0] == 4'h1) begin
                    sr_q <= merge(sr_q, req.dat, req.sel);
                end else begin
                    gl_q[reg_sel_q[3:0]] <=
                        merge(gl_q[reg_sel_q[3:0]], req.dat, req.sel);
                end
            end
        end
    end

    // instruction latch and register selector
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            instr_q   <= '0;
            reg_sel_q <= 5'h00;
        end else if (bus_wr) begin
            if (req.adr == ssct_pkg::OFS_OPCODE) begin
                if (req.sel[0]) instr_q.op[7:0]  <= req.dat[7:0];
                if (req.sel[1]) instr_q.op[15:8] <= req.dat[15:8];
            end else if (req.adr == ssct_pkg::OFS_EXT) begin
                if (req.sel[0]) instr_q.ext2[7:0]  <= req.dat[7:0];
                if (req.sel[1]) instr_q.ext2[15:8] <= req.dat[15:8];
                if (req.sel[2]) instr_q.ext1[7:0]  <= req.dat[23:16];
                if (req.sel[3]) instr_q.ext1[15:8] <= req.dat[31:24];
            end else if (req.adr == ssct_pkg::OFS_REG_SEL && req.sel[0]) begin
                reg_sel_q <= req.dat[4:0];
            end
        end
    end

    // memory store port for the stack store
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            store_valid_o <= 1'b0;
            store_addr_o  <= 32'h0000_0000;
            store_data_o  <= 32'h0000_0000;
        end else begin
            store_valid_o <= go && next_store;
            if (go && next_store) begin
                store_addr_o <= dst_val;
                store_data_o <= src_val;
            end
        end
    end

    // sticky events; a new event beats a clear in the same cycle
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ev_status_q <= '0;
            ev_enable_q <= '0;
        end else begin
            logic [ssct_pkg::EV_W-1:0] set;
            logic [ssct_pkg::EV_W-1:0] clr;
            set = '0;
            clr = '0;
            set[ssct_pkg::EV_RANGE] = go && next_range;
            set[ssct_pkg::EV_TRAP]  = go && next_trap;
            set[ssct_pkg::EV_STORE] = go && next_store;
            if (bus_wr && req.adr == ssct_pkg::OFS_EV_CLEAR &&
                req.sel[0]) begin
                clr = req.dat[ssct_pkg::EV_W-1:0];
            end
            ev_status_q <= (ev_status_q & ~clr) | set;
            if (bus_wr && req.adr == ssct_pkg::OFS_EV_ENABLE &&
                req.sel[0]) begin
                ev_enable_q <= req.dat[ssct_pkg::EV_W-1:0];
            end
        end
    end

    assign irq_o = |(ev_status_q & ev_enable_q);

    always_comb begin
        if (req.adr == ssct_pkg::OFS_OPCODE) begin
            next_rdata = {16'h0, instr_q.op};
        end else if (req.adr == ssct_pkg::OFS_EXT) begin
            next_rdata = {instr_q.ext1, instr_q.ext2};
        end else if (req.adr == ssct_pkg::OFS_EV_STATUS) begin
            next_rdata = {29'h0, ev_status_q};
        end else if (req.adr == ssct_pkg::OFS_EV_ENABLE) begin
            next_rdata = {29'h0, ev_enable_q};
        end else if (req.adr == ssct_pkg::OFS_PC) begin
            next_rdata = pc_q;
        end else if (req.adr == ssct_pkg::OFS_SR) begin
            next_rdata = sr_q;
        end else if (req.adr == ssct_pkg::OFS_REG_SEL) begin
            next_rdata = {27'h0, reg_sel_q};
        end else if (req.adr == ssct_pkg::OFS_REG_DATA) begin
            next_rdata = rd_reg(reg_sel_q[4], reg_sel_q[3:0]);
        end else if (req.adr == ssct_pkg::OFS_STORE_ADDR) begin
            next_rdata = store_addr_o;
        end else if (req.adr == ssct_pkg::OFS_STORE_DATA) begin
            next_rdata = store_data_o;
        end else begin
            next_rdata = 32'h0000_0000;
        end
    end

    // unmapped or write-only offsets still ack, reading zero
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req.cyc && req.stb && !wb_ack_o;
            if (bus_rd) begin
                wb_dat_o <= next_rdata;
            end
        end
    end

endmodule : ssct_exec

//--- testbench/ssct_exec_chk.sv
// port-level checks for the execution unit
module ssct_exec_chk (
    input wire logic        clk_sys_i,
    input wire logic        arst_n_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        irq_o,
    input wire logic        store_valid_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    logic go_ack;
    assign go_ack = wb_ack_o && wb_we_i && wb_adr_i == ssct_pkg::OFS_GO;
    ack_on_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack missing after request");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_has_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    read_zero_a: assert property (wb_ack_o && !wb_we_i && (wb_adr_i > 8'h2F
        || wb_adr_i == ssct_pkg::OFS_GO) |-> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    store_after_go_a: assert property (store_valid_o |-> $past(go_ack))
        else $error("store pulse without execution");
    store_pulse_a: assert property (store_valid_o |=> !store_valid_o)
        else $error("store pulse too long");
    irq_off_a: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] &&
        wb_adr_i == ssct_pkg::OFS_EV_ENABLE && wb_dat_i[2:0] == 3'h0
        |=> !irq_o) else $error("irq while all masked");
    irq_rise_a: assert property ($rose(irq_o) |-> $past(wb_ack_o && wb_we_i))
        else $error("irq rose without a write");
endmodule : ssct_exec_chk

bind ssct_exec ssct_exec_chk ssct_exec_chk_i (.clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_o(irq_o), .store_valid_o(store_valid_o));

//--- testbench/ssct_exec_tb_top.sv
// self-checking bench for the execution unit
module ssct_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] RANGE_ENTRY = 32'hFFFF_FE00;
    logic                      clk_sys_i = 1'b0;
    logic                      arst_n_i  = 1'b0;
    ssct_pkg::ssct_wb_req_type req       = '0;
    logic [31:0]               rdat;
    logic [31:0]               q;
    logic                      ack;
    logic                      irq;
    int                        bad_count = 0;
    int                        n_checks  = 0;
    int                        cycles    = 0;

    always #12.5 clk_sys_i = ~clk_sys_i;

    ssct_exec #(.RANGE_ERR_ENTRY(RANGE_ENTRY)) ssct_exec_i (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .wb_cyc_i(req.cyc),
        .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_adr_i(req.adr),
        .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq_o(irq), .store_valid_o(),
        .store_addr_o(), .store_data_o());

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // request held until ack is sampled, released after that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
        do @(posedge clk_sys_i); while (ack !== 1'b1);
        q = rdat;
        req <= '0;
    endtask : wb

    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask : rd

    task automatic setr(input logic [4:0] r, input logic [31:0] v);
        wb(1'b1, ssct_pkg::OFS_REG_SEL, {27'h0, r});
        wb(1'b1, ssct_pkg::OFS_REG_DATA, v);
    endtask : setr

    task automatic getr(input string n, input logic [4:0] r, input logic [31:0] e);
        wb(1'b1, ssct_pkg::OFS_REG_SEL, {27'h0, r});
        rd(n, ssct_pkg::OFS_REG_DATA, e);
    endtask : getr

    // other status fields may move with execution, so only flags compared
    task automatic flags(input logic [3:0] e);
        wb(1'b0, ssct_pkg::OFS_SR, 32'h0);
        chk("flags", {28'h0, e}, {28'h0, q[3:0]});
    endtask : flags

    task automatic exec(input logic [15:0] op, input logic [31:0] ext);
        wb(1'b1, ssct_pkg::OFS_OPCODE, {16'h0, op});
        wb(1'b1, ssct_pkg::OFS_EXT, ext);
        wb(1'b1, ssct_pkg::OFS_GO, 32'h0);
    endtask : exec

    function automatic logic [15:0] rr(input logic [5:0] o, input logic [4:0] d,
                                       input logic [4:0] s);
        return {o, d[4], s[4], d[3:0], s[3:0]};
    endfunction : rr

    task automatic t_sub();
        rd("pc reset", ssct_pkg::OFS_PC, ssct_pkg::PC_RESET);
        rd("unmapped", 8'h30, 32'h0);
        setr(5'h02, 32'h5);
        setr(5'h03, 32'h7);
        exec(rr(ssct_pkg::OPC_SUB, 5'h02, 5'h03), 32'h0);
        getr("sub", 5'h02, 32'hFFFF_FFFE);
        flags(4'h5);
        exec(rr(ssct_pkg::OPC_SUB, 5'h02, 5'h01), 32'h0);
        getr("sub carry", 5'h02, 32'hFFFF_FFFD);
        exec(rr(ssct_pkg::OPC_SUB_BORROW, 5'h04, 5'h05), 32'h0);
        flags(4'h0);
        $display("test sub done");
    endtask : t_sub

    task automatic t_range();
        wb(1'b1, ssct_pkg::OFS_EV_ENABLE, 32'h1);
        wb(1'b1, ssct_pkg::OFS_SR, 32'h1);
        setr(5'h02, 32'h8000_0000);
        setr(5'h03, 32'h1);
        exec(rr(ssct_pkg::OPC_SUB_TRAP, 5'h02, 5'h03), 32'h0);
        getr("signed_subtract_trap", 5'h02, 32'h7FFF_FFFF);
        flags(4'h9);
        rd("range pc", ssct_pkg::OFS_PC, RANGE_ENTRY);
        chk("irq", 32'h1, {31'h0, irq});
        wb(1'b1, ssct_pkg::OFS_EV_CLEAR, 32'h7);
        rd("status", ssct_pkg::OFS_EV_STATUS, 32'h0);
        chk("irq cleared", 32'h0, {31'h0, irq});
        exec(rr(ssct_pkg::OPC_SUM_TRAP, 5'h02, 5'h02), 32'h0001_0000);
        getr("signed_add_immediate_trap", 5'h02, 32'h8000_0000);
        flags(4'hD);
        rd("status", ssct_pkg::OFS_EV_STATUS, 32'h1);
        wb(1'b1, ssct_pkg::OFS_EV_ENABLE, 32'h0);
        $display("test range done");
    endtask : t_range

    task automatic t_sum();
        wb(1'b1, ssct_pkg::OFS_SR, 32'h0);
        exec(rr(ssct_pkg::OPC_SUM, 5'h02, 5'h03), 32'h7FFF_0000);
        getr("sum short", 5'h02, 32'h0);
        flags(4'h3);
        exec(rr(ssct_pkg::OPC_SUM, 5'h02, 5'h04), 32'hC000_0000);
        getr("sum long", 5'h02, 32'hC000_0000);
        flags(4'h4);
        wb(1'b1, ssct_pkg::OFS_SR, 32'h5);
        setr(5'h11, 32'h0);
        exec({ssct_pkg::OPC_LZ_COUNT, 4'h2, 4'h1}, 32'h0);
        getr("clz zero", 5'h12, 32'h20);
        flags(4'h5);
        setr(5'h11, 32'h0001_0000);
        exec({ssct_pkg::OPC_LZ_COUNT, 4'h2, 4'h1}, 32'h0);
        getr("clz", 5'h12, 32'hF);
        $display("test sum done");
    endtask : t_sum

    task automatic t_trap();
        wb(1'b1, ssct_pkg::OFS_SR, 32'h0040_0000);
        wb(1'b1, ssct_pkg::OFS_PC, 32'h100);
        exec(16'hFF14, 32'h0);
        rd("no trap pc", ssct_pkg::OFS_PC, 32'h102);
        exec(16'hFC17, 32'h0);
        rd("code three", ssct_pkg::OFS_PC, 32'h104);
        exec(16'hFF17, 32'h0);
        rd("trap pc", ssct_pkg::OFS_PC, 32'hFFFF_FF14);
        rd("trap event", ssct_pkg::OFS_EV_STATUS, 32'h3);
        wb(1'b0, ssct_pkg::OFS_SR, 32'h0);
        chk("trap sr", 32'h04C0_00C0, q & 32'hFFFF_FCFF);
        getr("ret slot", 5'h10, 32'h106);
        getr("sr slot", 5'h11, 32'h0040_0100);
        $display("test trap done");
    endtask : t_trap

    task automatic t_store();
        wb(1'b1, ssct_pkg::OFS_SR, 32'h0);
        setr(5'h02, 32'h1000);
        setr(5'h03, 32'hABCD);
        exec(rr(ssct_pkg::OPC_STACK_STORE, 5'h02, 5'h03), 32'h4FFC_0000);
        rd("store addr", ssct_pkg::OFS_STORE_ADDR, 32'h1000);
        rd("store data", ssct_pkg::OFS_STORE_DATA, 32'hABCD);
        getr("post update", 5'h02, 32'hFFC);
        $display("test store done");
    endtask : t_store

    initial begin
        repeat (20) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        t_sub();
        t_range();
        t_sum();
        t_trap();
        t_store();
        report_and_stop();
    end

    // roughly 335 cycles expected, ceiling leaves ample margin
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            report_and_stop();
        end
    end
endmodule : ssct_exec_tb_top
